// file: pkg/lcd_pkg.sv
package lcd_pkg;

    localparam int NCH = 4;
    localparam int CH_W = 2;
    localparam int CNT_W = 16;
    localparam int AMP_W = 16;
    localparam int MS_W = 8;
    localparam int CYC_W = 10;

    // Alignment cause bit positions
    localparam int CAUSE_W = 7;
    localparam int CA_MEAS = 0;
    localparam int CA_NORM = 1;
    localparam int CA_PARTNER = 2;
    localparam int CA_HOLD = 3;
    localparam int CA_USER = 4;
    localparam int CA_SYNC = 5;
    localparam int CA_MON = 6;

    // Reset cause bit positions
    localparam int RC_W = 4;
    localparam int RC_POR = 0;
    localparam int RC_BUTTON = 1;
    localparam int RC_PARAM = 2;
    localparam int RC_WDOG = 3;
    localparam logic [RC_W-1:0] RST_CAUSE_POR = 4'h1;

    localparam logic [15:0] IND_STEP_UH = 16'h000a;

    localparam int CLK_HZ = 25_000_000;
    localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
    localparam int LED_HZ_X10 = 5;
    localparam int LED_HALF_DEF = (CLK_HZ * 10) / (2 * LED_HZ_X10);
    localparam int LOSS_MS = 20;
    localparam int LOSS_DEF = LOSS_MS * MS_CYCLES_DEF;
    localparam logic [CYC_W-1:0] CYCLE_MAX_MS = 10'h008;

    // Sync line gaps between slots, in clock cycles
    localparam logic [31:0] GAP_SLOT = 32'h0000_0002;
    localparam logic [31:0] GAP_FRAME = 32'h0000_0006;
    localparam logic [31:0] FRAME_MIN = 32'h0000_0004;

    typedef enum logic [1:0] {SL_MEAS, SL_WAIT, SL_GAP} lcd_slot_e;

    typedef struct packed {
        logic occ;
        logic err;
        logic hist;
        logic [CNT_W-1:0] align_cnt;
        logic [CNT_W-1:0] hold_cnt;
        logic [CAUSE_W-1:0] cause;
        logic [AMP_W-1:0] amp_max;
        logic [AMP_W-1:0] last_peak;
        logic [15:0] ind_10uh;
    } lcd_chan_diag_s;

    typedef struct packed {
        logic [CNT_W-1:0] rst_cnt;
        logic [RC_W-1:0] rst_cause;
        logic [CYC_W-1:0] cycle_ms;
        logic synced;
        logic leader;
    } lcd_dev_diag_s;

endpackage

// file: rtl/lcd_diag_sync.sv
`timescale 1ns/1ps
module lcd_diag_sync #(
    parameter int MS_CYCLES = lcd_pkg::MS_CYCLES_DEF,
    parameter int LED_HALF_CYCLES = lcd_pkg::LED_HALF_DEF,
    parameter int LOSS_CYCLES = lcd_pkg::LOSS_DEF
)(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [lcd_pkg::NCH-1:0][lcd_pkg::AMP_W-1:0] amp_i,
    input wire logic [lcd_pkg::NCH-1:0][lcd_pkg::AMP_W-1:0] thr_i,
    input wire logic [lcd_pkg::NCH-1:0] err_i,
    input wire logic [lcd_pkg::NCH-1:0][15:0] ind_uh_i,
    input wire logic [lcd_pkg::NCH-1:0][lcd_pkg::MS_W-1:0] meas_ms_i,
    input wire logic hold_inf_i,
    input wire logic [lcd_pkg::NCH-1:0] hold_exc_i,
    input wire logic [lcd_pkg::NCH-1:0] meas_exc_i,
    input wire logic [lcd_pkg::NCH-1:0] norm_low_i,
    input wire logic [lcd_pkg::NCH-1:0] user_align_i,
    input wire logic [lcd_pkg::NCH-1:0] stuck_i,
    input wire logic cnt_clear_i,
    input wire logic req_i,
    input wire logic leader_en_i,
    input wire logic soft_rst_i,
    input wire logic [lcd_pkg::RC_W-1:0] soft_cause_i,
    input wire logic sync_i,
    output logic sync_o,
    output logic sync_oe_o,
    output logic [lcd_pkg::NCH-1:0] occ_o,
    output logic [lcd_pkg::NCH-1:0] align_o,
    output logic [lcd_pkg::NCH-1:0] recal_o,
    output logic [lcd_pkg::CH_W-1:0] meas_ch_o,
    output logic function_indicator_led_o,
    output logic leader_o,
    output logic synced_o,
    output logic cycle_long_o,
    output logic valid_o,
    output lcd_pkg::lcd_chan_diag_s [lcd_pkg::NCH-1:0] diag_o,
    output lcd_pkg::lcd_dev_diag_s dev_o
);
    import lcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Sync line and measurement slot sequencer

    logic sync_m;
    logic sync_s;
    logic sync_q;
    lcd_slot_e state;
    logic [CH_W-1:0] ch;
    logic [31:0] timer;
    logic synced;
    logic leader;
    logic sync_align;
    logic [2:0] drv_hist;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync_m <= 1'b1;
            sync_s <= 1'b1;
            sync_q <= 1'b1;
            drv_hist <= '0;
        end
        else if (ce_i)
        begin
            sync_m <= sync_i;
            sync_s <= sync_m;
            sync_q <= sync_s;
            drv_hist <= {drv_hist[1:0], sync_oe_o};
        end
    end

    wire coupled = leader | synced;
    wire sync_fall = sync_q & ~sync_s;
    wire [31:0] slot_len = 32'(meas_ms_i[ch]) * 32'(MS_CYCLES);
    wire meas_done = (state == SL_MEAS) && (timer + 32'h0000_0001 >= slot_len);
    wire last_ch = (ch == CH_W'(NCH - 1));
    wire [31:0] gap_len = last_ch ? GAP_FRAME : GAP_SLOT;
    wire lead_go = leader && (state == SL_GAP) && (timer + 32'h0000_0001 >= gap_len);
    wire foll_go = synced && (state == SL_GAP) && !sync_s;
    wire [CH_W-1:0] foll_ch = (timer >= FRAME_MIN) ? '0 : CH_W'(ch + 1'b1);
    wire lost = synced && (state == SL_GAP) && sync_s && (timer >= 32'(LOSS_CYCLES));
    // A unit that has just left the leader role still sees its own last edge
    // in the synchroniser; it must not follow that echo of itself.
    wire acquire = !leader && !synced && sync_fall && !(|drv_hist);
    wire frame_go = (lead_go && last_ch) || (foll_go && foll_ch == '0)
        || (!coupled && meas_done && last_ch);

    // Each coupled unit holds the line low while measuring; the wired line
    // rises only when the slowest detector finishes its slot.
    assign sync_oe_o = coupled && (state == SL_MEAS);
    assign sync_o = 1'b0;
    assign meas_ch_o = ch;
    assign leader_o = leader;
    assign synced_o = synced;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= SL_MEAS;
            ch <= '0;
            timer <= 32'h0000_0000;
            synced <= 1'b0;
            leader <= 1'b0;
            sync_align <= 1'b0;
        end
        else if (ce_i)
        begin
            // Leader role change counts no alignment; acquiring or losing sync counts an alignment
            leader <= leader_en_i & (leader | ~synced);
            sync_align <= acquire | lost;
            if (acquire)
                synced <= 1'b1;
            else if (lost)
                synced <= 1'b0;
            if (acquire)
            begin
                state <= SL_MEAS;
                ch <= '0;
                timer <= 32'h0000_0000;
            end
            else if (!coupled && state != SL_MEAS)
            begin
                state <= SL_MEAS;
                timer <= 32'h0000_0000;
            end
            else
            begin
                unique case (state)
                    SL_MEAS:
                    begin
                        if (meas_done)
                        begin
                            timer <= 32'h0000_0000;
                            if (coupled)
                                state <= SL_WAIT;
                            else
                                ch <= CH_W'(ch + 1'b1);
                        end
                        else
                            timer <= timer + 32'h0000_0001;
                    end
                    SL_WAIT:
                    begin
                        if (sync_s)
                        begin
                            state <= SL_GAP;
                            timer <= 32'h0000_0000;
                        end
                    end
                    SL_GAP:
                    begin
                        timer <= timer + 32'h0000_0001;
                        if (lead_go || foll_go)
                        begin
                            state <= SL_MEAS;
                            timer <= 32'h0000_0000;
                            ch <= lead_go ? CH_W'(ch + 1'b1) : foll_ch;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel diagnostics

    logic [NCH-1:0] own_ev;
    logic [NCH-1:0] align_now;
    logic [NCH:0][CYC_W-1:0] psum;
    lcd_chan_diag_s [NCH-1:0] live;

    assign psum[0] = '0;

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        localparam int P = i ^ 1;
        logic occ;
        logic err;
        logic hist;
        logic [CNT_W-1:0] acnt;
        logic [CNT_W-1:0] hcnt;
        logic [CAUSE_W-1:0] cause;
        logic [CAUSE_W-1:0] own_c;
        logic [AMP_W-1:0] amax;
        logic [AMP_W-1:0] prun;
        logic [AMP_W-1:0] plast;
        logic [15:0] ind;

        wire hold_ev = hold_exc_i[i] & ~hold_inf_i;
        wire over = amp_i[i] > thr_i[i];
        wire [AMP_W-1:0] pk = (amp_i[i] > prun) ? amp_i[i] : prun;

        always_comb
        begin
            own_c = '0;
            own_c[CA_MEAS] = meas_exc_i[i];
            own_c[CA_NORM] = norm_low_i[i];
            own_c[CA_HOLD] = hold_ev;
            own_c[CA_USER] = user_align_i[i];
            own_c[CA_SYNC] = sync_align;
            own_c[CA_MON] = stuck_i[i] | stuck_i[P];
        end

        assign own_ev[i] = |own_c;
        assign align_now[i] = own_ev[i] | own_ev[P];
        wire [CAUSE_W-1:0] next_c = own_c | (CAUSE_W'(own_ev[P]) << CA_PARTNER);
        assign psum[i+1] = psum[i] + CYC_W'(meas_ms_i[i]);

        always_ff @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                occ <= 1'b0;
                err <= 1'b0;
                hist <= 1'b0;
                acnt <= '0;
                hcnt <= '0;
                cause <= '0;
                amax <= '0;
                prun <= '0;
                plast <= '0;
                ind <= '0;
            end
            else if (ce_i)
            begin
                occ <= over;
                err <= err_i[i];
                hist <= hist | err_i[i];
                // A new event in the clear cycle survives the clear
                acnt <= (cnt_clear_i ? '0 : acnt) + CNT_W'(align_now[i]);
                hcnt <= (cnt_clear_i ? '0 : hcnt) + CNT_W'(hold_ev);
                cause <= (cnt_clear_i ? '0 : cause) | next_c;
                if (align_now[i] || cnt_clear_i)
                    amax <= '0;
                else if (amp_i[i] > amax)
                    amax <= amp_i[i];
                prun <= over ? pk : '0;
                if (cnt_clear_i)
                    plast <= '0;
                else if (occ && !over)
                    plast <= prun;
                ind <= 16'(ind_uh_i[i] / IND_STEP_UH);
            end
        end

        assign live[i] = '{occ: occ, err: err, hist: hist, align_cnt: acnt,
            hold_cnt: hcnt, cause: cause, amp_max: amax, last_peak: plast,
            ind_10uh: ind};
        assign occ_o[i] = occ;
    end

    ////////////////////////////////////////////////////////////////////////
    // Device values, LED, outputs and snapshot

    logic [CNT_W-1:0] rst_cnt;
    logic [RC_W-1:0] rst_cause;
    logic [31:0] frame_cyc;
    logic [CYC_W-1:0] cyc_meas;
    logic [31:0] led_cnt;
    logic led_ph;

    wire [CYC_W-1:0] cyc_ms = coupled ? cyc_meas : psum[NCH];
    wire lcd_dev_diag_s dev_live = '{rst_cnt: rst_cnt, rst_cause: rst_cause,
        cycle_ms: cyc_ms, synced: synced, leader: leader};

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_cnt <= '0;
            rst_cause <= RST_CAUSE_POR;
            frame_cyc <= 32'h0000_0000;
            cyc_meas <= '0;
            led_cnt <= 32'h0000_0000;
            led_ph <= 1'b0;
            function_indicator_led_o <= 1'b0;
            align_o <= '0;
            recal_o <= '0;
            cycle_long_o <= 1'b0;
            valid_o <= 1'b0;
            diag_o <= '0;
            dev_o <= '0;
        end
        else if (ce_i)
        begin
            rst_cnt <= (cnt_clear_i ? '0 : rst_cnt) + CNT_W'(soft_rst_i);
            if (soft_rst_i)
                rst_cause <= soft_cause_i;
            else if (cnt_clear_i)
                rst_cause <= '0;
            // Measured frame length covers the slowest detector of each slot
            if (frame_go)
            begin
                cyc_meas <= CYC_W'(frame_cyc / 32'(MS_CYCLES));
                frame_cyc <= 32'h0000_0001;
            end
            else
                frame_cyc <= frame_cyc + 32'h0000_0001;
            // Phase restarts on acquisition so followers line up with the leader
            if (!coupled || sync_align || led_cnt + 32'h0000_0001 >= 32'(LED_HALF_CYCLES))
                led_cnt <= 32'h0000_0000;
            else
                led_cnt <= led_cnt + 32'h0000_0001;
            if (!coupled || sync_align)
                led_ph <= 1'b0;
            else if (led_cnt + 32'h0000_0001 >= 32'(LED_HALF_CYCLES))
                led_ph <= ~led_ph;
            function_indicator_led_o <= coupled ? (led_ph ^ leader) : 1'b1;
            align_o <= align_now;
            recal_o <= norm_low_i;
            cycle_long_o <= cyc_ms > CYCLE_MAX_MS;
            valid_o <= req_i;
            if (req_i)
            begin
                diag_o <= live;
                dev_o <= dev_live;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    occ_follows_amp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i |=> occ_o[0] == $past(amp_i[0] > thr_i[0]))
        else $error("occupied flag does not follow threshold compare");
    hist_sticky_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        live[0].hist |=> live[0].hist)
        else $error("error history cleared without power-on reset");
    pair_align_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        own_ev[0] |-> align_now[1] && align_now[0])
        else $error("partner channel not aligned");
    hold_inf_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && hold_inf_i && !cnt_clear_i |=> $stable(live[0].hold_cnt))
        else $error("hold counter moved with infinite hold time");
    align_count_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && align_now[0] && !cnt_clear_i
        |=> live[0].align_cnt == CNT_W'($past(live[0].align_cnt) + 1'b1))
        else $error("alignment not counted");
    leader_refuse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        synced |-> !leader)
        else $error("leader role taken while synchronised");
    clear_cnt_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && cnt_clear_i && !soft_rst_i |=> rst_cnt == '0 && live[0].amp_max == '0)
        else $error("counters not cleared");
    snapshot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && req_i |=> valid_o && diag_o == $past(live) && dev_o == $past(dev_live))
        else $error("snapshot does not match live values");
    follow_slot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && foll_go && !acquire |=> state == SL_MEAS && timer == 32'h0000_0000)
        else $error("follower did not start slot on leader edge");

endmodule

// file: tb/lcd_peer_model.sv
`timescale 1ns/1ps
// Peer detector on the shared sync line, as leader or as follower
module lcd_peer_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic line_i,
    input wire logic lead_i,
    input wire logic [15:0] slot_i,
    output logic oe_o,
    output logic [1:0] ch_o
);
    logic [15:0] cnt;
    logic [1:0] st;
    logic prev;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            oe_o <= 1'b0;
            cnt <= 16'h0000;
            st <= 2'h0;
            ch_o <= 2'h3;
            prev <= 1'b1;
        end
        else
        begin
            prev <= line_i;
            case (st)
                2'h0:
                    if (lead_i && cnt == 16'h0000)
                    begin
                        // Leader opens the next slot; one channel for all units
                        oe_o <= 1'b1;
                        cnt <= slot_i;
                        st <= 2'h1;
                        ch_o <= ch_o + 2'h1;
                    end
                    else if (lead_i)
                        cnt <= cnt - 16'h0001;
                    else if (prev && !line_i)
                    begin
                        // Follower holds the line for its own, longer slot
                        oe_o <= 1'b1;
                        cnt <= slot_i;
                        st <= 2'h1;
                    end
                2'h1:
                    if (cnt <= 16'h0001)
                    begin
                        oe_o <= 1'b0;
                        st <= lead_i ? 2'h2 : 2'h0;
                    end
                    else
                        cnt <= cnt - 16'h0001;
                default:
                    if (line_i)
                    begin
                        // Longer gap marks the frame start
                        st <= 2'h0;
                        cnt <= (ch_o == 2'h3) ? 16'h0006 : 16'h0002;
                    end
            endcase
        end
    end
endmodule

// file: tb/test_lcd_diag_sync.sv
`timescale 1ns/1ps
module test_lcd_diag_sync;
    import lcd_pkg::*;
    logic clk_i = 0, resetn_i = 0, ce_i = 1, hold_inf_i = 0, cnt_clear_i = 0, req_i = 0;
    logic leader_en_i = 0, soft_rst_i = 0, peer_lead = 0;
    logic [NCH-1:0][AMP_W-1:0] amp_i = '0, thr_i = {4{16'h0100}};
    logic [NCH-1:0][15:0] ind_uh_i = '0;
    logic [NCH-1:0][MS_W-1:0] meas_ms_i = {4{8'h01}};
    logic [NCH-1:0] err_i = '0, hold_exc_i = '0, meas_exc_i = '0, norm_low_i = '0;
    logic [NCH-1:0] user_align_i = '0, stuck_i = '0, occ_o, align_o, recal_o;
    logic [RC_W-1:0] soft_cause_i = '0;
    logic sync_o, sync_oe_o, peer_oe, function_indicator_led_o, leader_o, synced_o;
    logic cycle_long_o, valid_o;
    logic [CH_W-1:0] meas_ch_o, peer_ch;
    lcd_chan_diag_s [NCH-1:0] diag_o;
    lcd_dev_diag_s dev_o;
    wire sync_line = !(sync_oe_o || peer_oe);
    int miscompares = 0, checked = 0, i, n, k;
    logic [CNT_W-1:0] a;
    lcd_diag_sync #(.MS_CYCLES(10), .LED_HALF_CYCLES(20), .LOSS_CYCLES(200)) lcd_diag_sync_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .amp_i(amp_i), .thr_i(thr_i),
        .err_i(err_i), .ind_uh_i(ind_uh_i), .meas_ms_i(meas_ms_i), .hold_inf_i(hold_inf_i),
        .hold_exc_i(hold_exc_i), .meas_exc_i(meas_exc_i), .norm_low_i(norm_low_i),
        .user_align_i(user_align_i), .stuck_i(stuck_i), .cnt_clear_i(cnt_clear_i),
        .req_i(req_i), .leader_en_i(leader_en_i), .soft_rst_i(soft_rst_i),
        .soft_cause_i(soft_cause_i), .sync_i(sync_line), .sync_o(sync_o),
        .sync_oe_o(sync_oe_o), .occ_o(occ_o), .align_o(align_o), .recal_o(recal_o),
        .meas_ch_o(meas_ch_o), .function_indicator_led_o(function_indicator_led_o),
        .leader_o(leader_o), .synced_o(synced_o), .cycle_long_o(cycle_long_o),
        .valid_o(valid_o), .diag_o(diag_o), .dev_o(dev_o));
    lcd_peer_model lcd_peer_model_i (.clk_i(clk_i), .resetn_i(resetn_i), .line_i(sync_line),
        .lead_i(peer_lead), .slot_i(16'h001e), .oe_o(peer_oe), .ch_o(peer_ch));
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    // A wait that ran out of its bound ends the run
    task bound(input int c, input int lim);
        if (c >= lim)
        begin
            miscompares++;
            final_report;
        end
    endtask
    task snap;
        req_i = 1;
        tick(1);
        req_i = 0;
        chk(valid_o, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(20);
        resetn_i = 1;
        tick(2);
        chk(function_indicator_led_o, 1);
        snap;
        chk(dev_o.rst_cause, RST_CAUSE_POR);
        chk(diag_o[0].align_cnt, 0);
        chk(dev_o.cycle_ms, 4);
        meas_ms_i = {8'h02, 8'h03, 8'h02, 8'h01};
        ind_uh_i[1] = 16'h04d2;
        tick(3);
        chk(diag_o[1].ind_10uh, 0);
        snap;
        chk(dev_o.cycle_ms, 8);
        chk(cycle_long_o, 0);
        chk(diag_o[1].ind_10uh, 16'h007b);
        meas_ms_i = {4{8'h01}};
        $display("test reset and snapshot done");
        amp_i[2] = 16'h0300;
        tick(2);
        chk(occ_o[2], 1);
        amp_i[2] = 16'h0500;
        tick(1);
        amp_i[2] = 16'h0000;
        tick(2);
        chk(occ_o[2], 0);
        snap;
        chk(diag_o[2].amp_max, 16'h0500);
        chk(diag_o[2].last_peak, 16'h0500);
        $display("test occupancy done");
        // Four alignment sources on channel 2, spreading to channel 3, then hold on channel 0
        for (k = 0; k < 4; k++)
        begin
            case (k)
                0: meas_exc_i[2] = 1;
                1: norm_low_i[2] = 1;
                2: user_align_i[2] = 1;
                default: stuck_i[2] = 1;
            endcase
            tick(1);
            {meas_exc_i, norm_low_i, user_align_i, stuck_i} = '0;
            chk(align_o, 4'b1100);
            chk(recal_o[2], k == 1);
            snap;
            chk(diag_o[2].align_cnt, k + 1);
            chk(diag_o[3].align_cnt, k + 1);
            chk(diag_o[2].amp_max, 0);
            n = (k == 0) ? CA_MEAS : (k == 1) ? CA_NORM : (k == 2) ? CA_USER : CA_MON;
            chk(diag_o[2].cause[n], 1);
            if (k < 3)
                chk(diag_o[3].cause[CA_PARTNER], 1);
        end
        hold_exc_i[0] = 1;
        tick(1);
        hold_inf_i = 1;
        tick(1);
        hold_exc_i[0] = 0;
        hold_inf_i = 0;
        snap;
        chk(diag_o[0].hold_cnt, 1);
        chk(diag_o[0].align_cnt, 1);
        chk(diag_o[0].cause[CA_HOLD], 1);
        chk(diag_o[1].cause[CA_PARTNER], 1);
        $display("test alignment causes done");
        err_i[1] = 1;
        tick(2);
        err_i[1] = 0;
        soft_cause_i = 4'h4;
        soft_rst_i = 1;
        tick(1);
        soft_rst_i = 0;
        snap;
        chk({diag_o[1].err, diag_o[1].hist}, 2'b01);
        chk(dev_o.rst_cnt, 1);
        chk(dev_o.rst_cause, 4'h4);
        cnt_clear_i = 1;
        tick(1);
        cnt_clear_i = 0;
        snap;
        for (k = 0; k < 4; k++)
            chk({diag_o[k].align_cnt, diag_o[k].hold_cnt, diag_o[k].cause}, 0);
        chk({diag_o[2].amp_max, diag_o[2].last_peak}, 0);
        chk({dev_o.rst_cnt, dev_o.rst_cause}, 0);
        chk(diag_o[1].hist, 1);
        $display("test clear done");
        // Leader with a slower follower peer
        amp_i[0] = 16'h0300;
        leader_en_i = 1;
        for (i = 0; i < 20 && leader_o !== 1'b1; i++) tick(1);
        bound(i, 20);
        chk(occ_o[0], 1);
        for (k = 0; k < 5; k++)
        begin
            a = meas_ch_o;
            for (i = 0; i < 500 && meas_ch_o === a; i++) tick(1);
            bound(i, 500);
            if (k > 0)
                chk(i >= 30, 1);
            chk(meas_ch_o, 2'(a[1:0] + 2'h1));
            chk({sync_oe_o, sync_o}, 2'b10);
        end
        tick(300);
        chk(cycle_long_o, 1);
        leader_en_i = 0;
        tick(300);
        $display("test leader done");
        // Follower of the peer leader
        peer_lead = 1;
        for (i = 0; i < 1000 && synced_o !== 1'b1; i++) tick(1);
        bound(i, 1000);
        tick(1);
        snap;
        chk(diag_o[0].cause[CA_SYNC], 1);
        a = diag_o[0].align_cnt;
        leader_en_i = 1;
        tick(5);
        chk(leader_o, 0);
        leader_en_i = 0;
        tick(150);
        for (k = 0; k < 6; k++)
        begin
            for (i = 0; i < 200 && peer_oe !== 1'b0; i++) tick(1);
            bound(i, 200);
            for (i = 0; i < 200 && peer_oe !== 1'b1; i++) tick(1);
            bound(i, 200);
            tick(8);
            chk(meas_ch_o, peer_ch);
        end
        n = function_indicator_led_o;
        for (i = 0; i < 100 && function_indicator_led_o === n[0]; i++) tick(1);
        bound(i, 100);
        for (i = 0; i < 100 && function_indicator_led_o !== n[0]; i++) tick(1);
        chk(i, 20);
        peer_lead = 0;
        for (i = 0; i < 1000 && synced_o !== 1'b0; i++) tick(1);
        bound(i, 1000);
        tick(1);
        snap;
        chk(diag_o[0].align_cnt, a + 1);
        $display("test follower done");
        final_report;
    end
endmodule
